/* ccs_pkg.sv */
// Constants and types for the core context, register and call stack block
//
// Overview of operation
// RL1: 8-bit sum register serves the ALU and sits in data space at FFh.
// RL2: Two pointer registers sit at 80h and 81h for indirect addressing.
// RL3: Two short-direct registers sit at 82h and 83h.
// RL4: A 12-bit instruction pointer addresses 4096 bytes of program space.
// RL5: A normal step advances the instruction pointer by one.
// RL6: Relative branch adds the signed offset through the adder into the pointer.
// RL7: Jump or call loads the pointer with the target address.
// RL8: Subroutine or interrupt exit loads the pointer from the stack top.
// RL9: Three carry/zero pairs: normal, interrupt and non-maskable contexts.
// RL10: Interrupt entry switches flag pair; interrupt exit restores the previous one. The code always exits irq to normal, even when irq was entered from nmi.
// RL11: Context switches keep flag values; only the active pair is reachable.
// RL12: Carry follows arithmetic carry or borrow, tested bit, and rotate left.
// RL13: Zero is set when the latest arithmetic or logic result is zero.
// RL14: Reset enters the non-maskable context and its flag pair.
// RL15: Six 12-bit stack levels outside data space, no visible pointer.
// RL16: Push shifts levels deeper, top takes the pointer, sixth is lost.
// RL17: Pop moves the top into the pointer and shifts levels up.
// RL18: Beyond six nested pushes the stack stays deepest; oldest address lost.
// RL19: Exit on an empty stack leaves it and steps to the next instruction.
// RL20: Software saves data-space registers itself inside subroutines.
// RL21: Reset clears the stack and points at the reset vector.
// RL22: Depth counter saturates at six on push and zero on pop.
// RL23: Other instructions leave the active carry and zero unchanged.
package ccs_pkg;

   // Data-space offsets of the mapped core registers
   localparam logic [7:0]  OFS_POINTER_ONE      = 8'h80;
   localparam logic [7:0]  OFS_POINTER_TWO      = 8'h81;
   localparam logic [7:0]  OFS_SHORT_DIRECT_ONE = 8'h82;
   localparam logic [7:0]  OFS_SECOND_SHORT_REG = 8'h83;
   localparam logic [7:0]  OFS_SUM_REGISTER     = 8'hFF;

   // Reset values
   localparam logic [11:0] RESET_VECTOR   = 12'hFFE;
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [11:0] LEVEL_RESET    = 12'h000;

   // Stack geometry
   localparam int          STACK_LEVELS   = 6;
   localparam logic [2:0]  STACK_FULL     = 3'h6;
   localparam logic [2:0]  STACK_EMPTY    = 3'h0;

   // Instruction pointer update sources
   typedef enum logic [3:0] {
      IP_HOLD     = 4'h0,
      IP_NEXT     = 4'h1,
      IP_REL      = 4'h2,
      IP_JUMP     = 4'h3,
      IP_CALL     = 4'h4,
      IP_SUB_EXIT = 4'h5,
      IP_INT_EXIT = 4'h6,
      IP_IRQ      = 4'h7,
      IP_NMI      = 4'h8
   } ccs_ip_op_e;

   // Execution contexts, one flag pair each
   typedef enum logic [1:0] {
      CTX_NORMAL = 2'h0,
      CTX_IRQ    = 2'h1,
      CTX_NMI    = 2'h2
   } ccs_ctx_e;

   // Flag update classes
   typedef enum logic [2:0] {
      FOP_NONE    = 3'h0,
      FOP_ARITH   = 3'h1,
      FOP_LOGIC   = 3'h2,
      FOP_BITTEST = 3'h3,
      FOP_ROTL    = 3'h4
   } ccs_flag_op_e;

endpackage : ccs_pkg

/* ccs_ctl_if.sv */
// Carrier between the core register block, its stack and its flag bank
`timescale 1ns/1ps
interface ccs_ctl_if;
   logic                  push;
   logic                  pop;
   logic [11:0]           push_ip;
   logic [11:0]           top_ip;
   logic [2:0]            depth;
   logic                  empty;
   ccs_pkg::ccs_ctx_e     ctx;
   ccs_pkg::ccs_flag_op_e flag_op;
   logic                  alu_carry;
   logic                  alu_zero;
   logic                  bit_value;
   logic                  carry;
   logic                  zero;

   modport stk_ctl (output push, pop, push_ip, input top_ip, depth, empty);
   modport stk     (input push, pop, push_ip, output top_ip, depth, empty);
   modport flg_ctl (output ctx, flag_op, alu_carry, alu_zero, bit_value,
                    input carry, zero);
   modport flg     (input ctx, flag_op, alu_carry, alu_zero, bit_value,
                    output carry, zero);
endinterface : ccs_ctl_if

/* ccs_stack.sv */
// Six-level shifting return stack with a saturating depth counter
`timescale 1ns/1ps
module ccs_stack (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   ccs_ctl_if.stk    bus
);
   logic [11:0] lvl_q [ccs_pkg::STACK_LEVELS];
   logic [2:0]  depth_q;

   assign bus.top_ip = lvl_q[0];
   assign bus.depth  = depth_q;
   assign bus.empty  = (depth_q == ccs_pkg::STACK_EMPTY);

   // Levels shift as a whole; no pointer exists, only the depth count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < ccs_pkg::STACK_LEVELS; i++) begin
            lvl_q[i] <= ccs_pkg::LEVEL_RESET; // RL21
         end
      end else if (bus.push) begin
         lvl_q[0] <= bus.push_ip; // RL16
         for (int i = 1; i < ccs_pkg::STACK_LEVELS; i++) begin
            lvl_q[i] <= lvl_q[i-1]; // RL15
         end
      end else if (bus.pop && !bus.empty) begin
         for (int i = 1; i < ccs_pkg::STACK_LEVELS; i++) begin
            lvl_q[i-1] <= lvl_q[i]; // RL17
         end
      end
   end

   // Saturation keeps overflow and underflow harmless
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         depth_q <= ccs_pkg::STACK_EMPTY;
      end else if (bus.push && depth_q != ccs_pkg::STACK_FULL) begin
         depth_q <= depth_q + 3'h1; // RL22 RL18
      end else if (!bus.push && bus.pop && !bus.empty) begin
         depth_q <= depth_q - 3'h1; // RL22
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_push_top;
      bus.push |=> lvl_q[0] == $past(bus.push_ip) && lvl_q[1] == $past(lvl_q[0]);
   endproperty
   a_push_top: assert property (p_push_top) else $error("push lost address"); // RL16

   property p_depth_sat;
      bus.push && depth_q == ccs_pkg::STACK_FULL |=> depth_q == ccs_pkg::STACK_FULL;
   endproperty
   a_depth_sat: assert property (p_depth_sat) else $error("depth overflowed"); // RL18

   property p_pop_shift;
      !bus.push && bus.pop && !bus.empty |=> lvl_q[0] == $past(lvl_q[1])
         && depth_q == $past(depth_q) - 3'h1;
   endproperty
   a_pop_shift: assert property (p_pop_shift) else $error("pop shift wrong"); // RL17
endmodule : ccs_stack

/* ccs_flags.sv */
// Three banked carry/zero pairs selected by the execution context
`timescale 1ns/1ps
module ccs_flags (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   ccs_ctl_if.flg    bus
);
   logic [2:0] carry_q;
   logic [2:0] zero_q;
   logic [1:0] sel;
   logic       upd_c;
   logic       upd_z;
   logic       new_c;

   assign sel = bus.ctx;
   // Logic ops leave carry alone; bit test leaves zero alone
   assign upd_c = bus.flag_op inside {ccs_pkg::FOP_ARITH, ccs_pkg::FOP_BITTEST,
                                      ccs_pkg::FOP_ROTL}; // RL12
   assign upd_z = bus.flag_op inside {ccs_pkg::FOP_ARITH, ccs_pkg::FOP_LOGIC,
                                      ccs_pkg::FOP_ROTL}; // RL13
   assign new_c = (bus.flag_op == ccs_pkg::FOP_BITTEST) ? bus.bit_value
                                                        : bus.alu_carry; // RL12
   // Only the active pair is seen or written
   assign bus.carry = carry_q[sel]; // RL11
   assign bus.zero  = zero_q[sel];  // RL11

   // Pairs are never cleared on a context switch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         carry_q <= 3'h0;
         zero_q  <= 3'h0;
      end else begin
         if (upd_c) begin
            carry_q[sel] <= new_c; // RL9
         end
         if (upd_z) begin
            zero_q[sel] <= bus.alu_zero; // RL23
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_zero;
      bus.flag_op == ccs_pkg::FOP_LOGIC |=> zero_q[$past(sel)] == $past(bus.alu_zero);
   endproperty
   a_zero: assert property (p_zero) else $error("zero not updated"); // RL13

   property p_bittest;
      bus.flag_op == ccs_pkg::FOP_BITTEST |=> carry_q[$past(sel)] == $past(bus.bit_value)
         && zero_q == $past(zero_q);
   endproperty
   a_bittest: assert property (p_bittest) else $error("bit test carry wrong"); // RL12

   property p_isolate;
      bus.flag_op != ccs_pkg::FOP_NONE && sel == ccs_pkg::CTX_NORMAL
         |=> carry_q[2:1] == $past(carry_q[2:1]) && zero_q[2:1] == $past(zero_q[2:1]);
   endproperty
   a_isolate: assert property (p_isolate) else $error("other pair disturbed"); // RL11
endmodule : ccs_flags

/* ccs_core_regs.sv */
// Core register file: instruction pointer, data-space registers, contexts
`timescale 1ns/1ps
module ccs_core_regs (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // Sequencer requests
   input  wire ccs_pkg::ccs_ip_op_e   ip_op,
   input  wire logic [11:0]           target_ip,
   input  wire logic [7:0]            rel_offset,
   // ALU result side
   input  wire ccs_pkg::ccs_flag_op_e flag_op,
   input  wire logic                  alu_carry,
   input  wire logic                  alu_zero,
   input  wire logic                  bit_value,
   input  wire logic                  sum_we,
   input  wire logic [7:0]            sum_wdata,
   // Data-space port
   input  wire logic [7:0]            ds_addr,
   input  wire logic                  ds_we,
   input  wire logic [7:0]            ds_wdata,
   input  wire logic                  ds_re,
   output logic [7:0]                 ds_rdata,
   output logic                       ds_hit,
   // Visible state
   output logic [11:0]                instruction_pointer,
   output logic [7:0]                 sum_register,
   output logic [7:0]                 pointer_one,
   output logic [7:0]                 pointer_two,
   output logic [7:0]                 short_direct_one,
   output logic [7:0]                 second_short_reg,
   output logic                       active_carry,
   output logic                       active_zero,
   output ccs_pkg::ccs_ctx_e          context_mode,
   output logic [2:0]                 stack_depth
);

   // Signed offset added through the pointer adder
   function automatic logic [11:0] rel_sum(input logic [11:0] ip,
                                           input logic [7:0]  off);
      rel_sum = ip + {{4{off[7]}}, off};
   endfunction : rel_sum

   // Sequential step, used by normal steps and by exits on an empty stack
   function automatic logic [11:0] ip_step(input logic [11:0] ip);
      ip_step = ip + 12'h001;
   endfunction : ip_step

   ccs_ctl_if ctl ();

   logic [11:0]       ip_q;
   logic [11:0]       ip_d;
   logic [7:0]        sum_q;
   logic [7:0]        ptr1_q;
   logic [7:0]        ptr2_q;
   logic [7:0]        sd1_q;
   logic [7:0]        sd2_q;
   logic [7:0]        rdata_q;
   logic [7:0]        rdata_d;
   logic              hit_q;
   logic              hit_d;
   ccs_pkg::ccs_ctx_e ctx_q;
   ccs_pkg::ccs_ctx_e ctx_d;
   ccs_pkg::ccs_ctx_e nmi_prev_q;
   logic              is_exit;
   logic              is_entry;
   logic              wr_sum;
   logic              wr_ptr1;
   logic              wr_ptr2;
   logic              wr_sd1;
   logic              wr_sd2;

   // Stack and flag bank
   ccs_stack u_stack (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .bus     (ctl.stk)
   );

   ccs_flags u_flags (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .bus     (ctl.flg)
   );

   // Control decode
   assign is_exit  = (ip_op == ccs_pkg::IP_SUB_EXIT) ||
                     (ip_op == ccs_pkg::IP_INT_EXIT);
   assign is_entry = (ip_op == ccs_pkg::IP_IRQ) || (ip_op == ccs_pkg::IP_NMI);

   // Stack requests; pushed value is the current instruction pointer
   assign ctl.push    = (ip_op == ccs_pkg::IP_CALL) || is_entry; // RL16
   assign ctl.pop     = is_exit; // RL17
   assign ctl.push_ip = ip_q;

   // Flag bank requests; flags follow the context in force this cycle
   assign ctl.ctx       = ctx_q; // RL9
   assign ctl.flag_op   = flag_op; // RL23
   assign ctl.alu_carry = alu_carry;
   assign ctl.alu_zero  = alu_zero;
   assign ctl.bit_value = bit_value;

   // Next instruction pointer selection
   always_comb begin
      ip_d = ip_q;
      case (ip_op)
         ccs_pkg::IP_HOLD: begin
            ip_d = ip_q;
         end
         ccs_pkg::IP_NEXT: begin
            ip_d = ip_step(ip_q); // RL5
         end
         ccs_pkg::IP_REL: begin
            ip_d = rel_sum(ip_q, rel_offset); // RL6
         end
         ccs_pkg::IP_JUMP, ccs_pkg::IP_CALL, ccs_pkg::IP_IRQ, ccs_pkg::IP_NMI: begin
            ip_d = target_ip; // RL7
         end
         ccs_pkg::IP_SUB_EXIT, ccs_pkg::IP_INT_EXIT: begin
            // Empty stack: the top stays put and execution just steps on
            ip_d = ctl.empty ? ip_step(ip_q) : ctl.top_ip; // RL8 RL19
         end
         default: begin
            ip_d = ip_q;
         end
      endcase
   end

   // Context selection; irq enters from any context and exits to normal, nmi nests over either
   always_comb begin
      ctx_d = ctx_q;
      case (ip_op)
         ccs_pkg::IP_IRQ: begin
            ctx_d = ccs_pkg::CTX_IRQ; // RL10
         end
         ccs_pkg::IP_NMI: begin
            ctx_d = ccs_pkg::CTX_NMI; // RL10
         end
         ccs_pkg::IP_INT_EXIT: begin
            ctx_d = (ctx_q == ccs_pkg::CTX_NMI) ? nmi_prev_q
                                                : ccs_pkg::CTX_NORMAL; // RL10
         end
         default: begin
            ctx_d = ctx_q;
         end
      endcase
   end

   // Instruction pointer; reset points at the vector location
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ip_q <= ccs_pkg::RESET_VECTOR; // RL21
      end else begin
         ip_q <= ip_d; // RL4
      end
   end

   // Context state; reset starts in the non-maskable context
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctx_q      <= ccs_pkg::CTX_NMI; // RL14
         nmi_prev_q <= ccs_pkg::CTX_NORMAL;
      end else begin
         ctx_q <= ctx_d;
         if (ip_op == ccs_pkg::IP_NMI && ctx_q != ccs_pkg::CTX_NMI) begin
            nmi_prev_q <= ctx_q;
         end
      end
   end

   // Data-space write strobes
   assign wr_sum  = ds_we && (ds_addr == ccs_pkg::OFS_SUM_REGISTER);     // RL1
   assign wr_ptr1 = ds_we && (ds_addr == ccs_pkg::OFS_POINTER_ONE);      // RL2
   assign wr_ptr2 = ds_we && (ds_addr == ccs_pkg::OFS_POINTER_TWO);      // RL2
   assign wr_sd1  = ds_we && (ds_addr == ccs_pkg::OFS_SHORT_DIRECT_ONE); // RL3
   assign wr_sd2  = ds_we && (ds_addr == ccs_pkg::OFS_SECOND_SHORT_REG); // RL3

   // Sum register; an ALU result wins over a same-cycle data-space write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sum_q <= ccs_pkg::REG_RESET;
      end else if (sum_we) begin
         sum_q <= sum_wdata; // RL1
      end else if (wr_sum) begin
         sum_q <= ds_wdata; // RL1
      end
   end

   // Pointer and short-direct registers, never saved on calls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr1_q <= ccs_pkg::REG_RESET;
         ptr2_q <= ccs_pkg::REG_RESET;
         sd1_q  <= ccs_pkg::REG_RESET;
         sd2_q  <= ccs_pkg::REG_RESET;
      end else begin
         if (wr_ptr1) ptr1_q <= ds_wdata; // RL2
         if (wr_ptr2) ptr2_q <= ds_wdata; // RL2
         if (wr_sd1)  sd1_q  <= ds_wdata; // RL3
         if (wr_sd2)  sd2_q  <= ds_wdata; // RL3
      end
   end

   // Read decode; unmapped offsets answer zero with the hit flag low
   always_comb begin
      rdata_d = 8'h00;
      hit_d   = 1'b1;
      case (ds_addr)
         ccs_pkg::OFS_SUM_REGISTER:     rdata_d = sum_q;
         ccs_pkg::OFS_POINTER_ONE:      rdata_d = ptr1_q;
         ccs_pkg::OFS_POINTER_TWO:      rdata_d = ptr2_q;
         ccs_pkg::OFS_SHORT_DIRECT_ONE: rdata_d = sd1_q;
         ccs_pkg::OFS_SECOND_SHORT_REG: rdata_d = sd2_q;
         default: begin
            rdata_d = 8'h00;
            hit_d   = 1'b0;
         end
      endcase
   end

   // Read data is registered; a read returns the value before a same-cycle write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         hit_q   <= 1'b0;
      end else begin
         rdata_q <= ds_re ? rdata_d : 8'h00;
         hit_q   <= ds_re && hit_d;
      end
   end

   // Outputs
   assign ds_rdata            = rdata_q;
   assign ds_hit              = hit_q;
   assign instruction_pointer = ip_q;
   assign sum_register        = sum_q;
   assign pointer_one         = ptr1_q;
   assign pointer_two         = ptr2_q;
   assign short_direct_one    = sd1_q;
   assign second_short_reg    = sd2_q;
   assign active_carry        = ctl.carry;
   assign active_zero         = ctl.zero;
   assign context_mode        = ctx_q;
   assign stack_depth         = ctl.depth;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_sum_write;
      ds_we && ds_addr == ccs_pkg::OFS_SUM_REGISTER && !sum_we;
   endsequence

   sequence s_sum_read;
      ds_re && ds_addr == ccs_pkg::OFS_SUM_REGISTER;
   endsequence

   property p_next;
      ip_op == ccs_pkg::IP_NEXT |=> ip_q == $past(ip_q) + 12'h001;
   endproperty
   a_next: assert property (p_next) else $error("step not by one"); // RL5

   property p_rel;
      ip_op == ccs_pkg::IP_REL
         |=> ip_q == $past(ip_q) + {{4{$past(rel_offset[7])}}, $past(rel_offset)};
   endproperty
   a_rel: assert property (p_rel) else $error("relative branch wrong"); // RL6

   property p_jump;
      ip_op inside {ccs_pkg::IP_JUMP, ccs_pkg::IP_CALL} |=> ip_q == $past(target_ip);
   endproperty
   a_jump: assert property (p_jump) else $error("target not loaded"); // RL7

   // A call, one idle cycle, then the exit that must hand back the pushed pointer
   property p_call_exit;
      ip_op == ccs_pkg::IP_CALL ##1 ip_op == ccs_pkg::IP_HOLD
         ##1 ip_op == ccs_pkg::IP_SUB_EXIT |=> ip_q == $past(ip_q, 3);
   endproperty
   a_call_exit: assert property (p_call_exit) else $error("return address lost"); // RL8

   property p_exit_empty;
      is_exit && ctl.empty |=> ip_q == $past(ip_q) + 12'h001 && ctl.empty;
   endproperty
   a_exit_empty: assert property (p_exit_empty) else $error("empty exit wrong"); // RL19

   property p_ctx_irq;
      ip_op == ccs_pkg::IP_INT_EXIT && ctx_q == ccs_pkg::CTX_IRQ
         |=> ctx_q == ccs_pkg::CTX_NORMAL;
   endproperty
   a_ctx_irq: assert property (p_ctx_irq) else $error("context not restored"); // RL10

   property p_flag_keep;
      flag_op == ccs_pkg::FOP_NONE && ctx_d == ctx_q
         |=> active_carry == $past(active_carry) && active_zero == $past(active_zero);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flags changed"); // RL23

   // Write, one cycle with no other write, then a read of the same location
   property p_sum_rw;
      logic [7:0] wval;
      (s_sum_write, wval = ds_wdata) ##1 (!sum_we && !wr_sum) ##1 s_sum_read
         |=> ds_rdata == wval;
   endproperty
   a_sum_rw: assert property (p_sum_rw) else $error("sum register readback"); // RL1

   property p_arith_flags;
      flag_op == ccs_pkg::FOP_ARITH && ctx_d == ctx_q
         |=> active_carry == $past(alu_carry) && active_zero == $past(alu_zero);
   endproperty
   a_arith_flags: assert property (p_arith_flags) else $error("arith flags"); // RL12
endmodule : ccs_core_regs

/* ccs_prog_mem.sv */
// Program memory model that supplies jump targets at the instruction pointer
`timescale 1ns/1ps
module ccs_prog_mem (
   input  wire logic [11:0] addr,
   output logic [11:0]      word
);
   logic [11:0] rom [0:4095];

   // Address-dependent fill, so a fetch from the wrong place shows up
   initial begin
      for (int i = 0; i < 4096; i++) begin
         rom[i] = 12'(i * 7 + 12'h1A3);
      end
   end

   // Fetch is combinational at the current pointer
   assign word = rom[addr];
endmodule : ccs_prog_mem

/* cpu_context_and_call_stack_tb.sv */
// Self-checking testbench for the core register, context and stack block
`timescale 1ns/1ps
module cpu_context_and_call_stack_tb;
   logic                  ref_clk, rst_n, alu_carry, alu_zero, bit_value;
   logic                  sum_we, ds_we, ds_re, ds_hit, active_carry, active_zero;
   logic [11:0]           target_ip, instruction_pointer, rom_word, e_ip;
   logic [7:0]            rel_offset, sum_wdata, ds_addr, ds_wdata, ds_rdata;
   logic [7:0]            sum_register, pointer_one, pointer_two;
   logic [7:0]            short_direct_one, second_short_reg;
   logic [2:0]            stack_depth;
   ccs_pkg::ccs_ip_op_e   ip_op;
   ccs_pkg::ccs_flag_op_e flag_op;
   ccs_pkg::ccs_ctx_e     context_mode;
   logic [11:0]           stk [$];
   logic [7:0]            regs_v [5];
   logic [7:0]            map [5];
   int                    n_fail, comparisons;

   ccs_core_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .ip_op(ip_op), .target_ip(target_ip),
      .rel_offset(rel_offset), .flag_op(flag_op), .alu_carry(alu_carry), .alu_zero(alu_zero),
      .bit_value(bit_value), .sum_we(sum_we), .sum_wdata(sum_wdata), .ds_addr(ds_addr),
      .ds_we(ds_we), .ds_wdata(ds_wdata), .ds_re(ds_re), .ds_rdata(ds_rdata), .ds_hit(ds_hit),
      .instruction_pointer(instruction_pointer), .sum_register(sum_register),
      .pointer_one(pointer_one), .pointer_two(pointer_two),
      .short_direct_one(short_direct_one), .second_short_reg(second_short_reg),
      .active_carry(active_carry), .active_zero(active_zero),
      .context_mode(context_mode), .stack_depth(stack_depth));

   ccs_prog_mem pm (.addr(instruction_pointer), .word(rom_word));

   // Mapped registers in the same order as their offsets
   assign regs_v = '{pointer_one, pointer_two, short_direct_one, second_short_reg, sum_register};
   assign map = '{ccs_pkg::OFS_POINTER_ONE, ccs_pkg::OFS_POINTER_TWO,
                  ccs_pkg::OFS_SHORT_DIRECT_ONE, ccs_pkg::OFS_SECOND_SHORT_REG,
                  ccs_pkg::OFS_SUM_REGISTER};

   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic cx(input ccs_pkg::ccs_ctx_e c, input logic cf, input logic zf);
      chk(12'(context_mode), 12'(c), "context");
      chk(12'({active_carry, active_zero}), 12'({cf, zf}), "flags");
   endtask : cx

   // Reset pulse of five cycles; the expected stack model is cleared with it
   task automatic rst();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      stk.delete();
      e_ip = ccs_pkg::RESET_VECTOR;
      chk(instruction_pointer, e_ip, "reset ip");
      chk(12'(stack_depth), 12'h000, "reset depth");
      cx(ccs_pkg::CTX_NMI, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) chk(12'(regs_v[i]), 12'h000, "reset reg");
   endtask : rst

   // One sequencer request; the expected pointer and stack follow the same step
   task automatic op(input ccs_pkg::ccs_ip_op_e o, input logic [11:0] t, input logic [7:0] r);
      @(posedge ref_clk);
      ip_op <= o;
      target_ip <= t;
      rel_offset <= r;
      @(posedge ref_clk);
      ip_op <= ccs_pkg::IP_HOLD;
      #1;
      case (o)
         ccs_pkg::IP_NEXT: e_ip++;
         ccs_pkg::IP_REL: e_ip += {{4{r[7]}}, r};
         ccs_pkg::IP_JUMP: e_ip = t;
         ccs_pkg::IP_CALL, ccs_pkg::IP_IRQ, ccs_pkg::IP_NMI: begin
            stk.push_front(e_ip);
            if (stk.size() > 6) void'(stk.pop_back());
            e_ip = t;
         end
         ccs_pkg::IP_SUB_EXIT, ccs_pkg::IP_INT_EXIT: begin
            e_ip = (stk.size() > 0) ? stk.pop_front() : e_ip + 12'h001;
         end
         default: ;
      endcase
      chk(instruction_pointer, e_ip, "ip");
      chk(12'(stack_depth), 12'(stk.size()), "depth");
   endtask : op

   task automatic fop(input ccs_pkg::ccs_flag_op_e f, input logic c, input logic z, input logic b);
      @(posedge ref_clk);
      flag_op <= f;
      alu_carry <= c;
      alu_zero <= z;
      bit_value <= b;
      @(posedge ref_clk);
      flag_op <= ccs_pkg::FOP_NONE;
      #1;
   endtask : fop

   // Data-space write; with sw set the ALU writes the inverse in the same cycle
   task automatic dsw(input logic [7:0] a, input logic [7:0] d, input logic sw);
      @(posedge ref_clk);
      ds_addr <= a;
      ds_wdata <= d;
      ds_we <= 1'b1;
      sum_we <= sw;
      sum_wdata <= ~d;
      @(posedge ref_clk);
      ds_we <= 1'b0;
      sum_we <= 1'b0;
      #1;
   endtask : dsw

   // Data-space read; answer stands one cycle only
   task automatic dsr(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      @(posedge ref_clk);
      ds_addr <= a;
      ds_re <= 1'b1;
      @(posedge ref_clk);
      ds_re <= 1'b0;
      #1;
      chk(12'(ds_rdata), 12'(exp), "read data");
      chk(12'(ds_hit), 12'(hit), "read hit");
      @(posedge ref_clk);
      #1;
      chk(12'(ds_hit), 12'h000, "hit stands one cycle");
   endtask : dsr

   // Main sequence
   initial begin
      {rst_n, alu_carry, alu_zero, bit_value, sum_we, ds_we, ds_re} = '0;
      {target_ip, rel_offset, sum_wdata, ds_addr, ds_wdata} = '0;
      ip_op = ccs_pkg::IP_HOLD;
      flag_op = ccs_pkg::FOP_NONE;
      rst();
      for (int i = 0; i < 5; i++) begin
         dsw(map[i], 8'hA0 + 8'(i), 1'b0);
         chk(12'(regs_v[i]), 12'(8'hA0 + 8'(i)), "reg");
         dsr(map[i], 8'hA0 + 8'(i), 1'b1);
      end
      dsr(8'h84, 8'h00, 1'b0);
      dsw(ccs_pkg::OFS_SUM_REGISTER, 8'h11, 1'b1);
      chk(12'(sum_register), 12'h0EE, "alu write");
      fop(ccs_pkg::FOP_ARITH, 1'b1, 1'b1, 1'b0);
      cx(ccs_pkg::CTX_NMI, 1'b1, 1'b1);
      op(ccs_pkg::IP_JUMP, rom_word, 8'h00);
      op(ccs_pkg::IP_INT_EXIT, 12'h000, 8'h00);
      cx(ccs_pkg::CTX_NORMAL, 1'b0, 1'b0);
      fop(ccs_pkg::FOP_ARITH, 1'b1, 1'b0, 1'b0);
      fop(ccs_pkg::FOP_LOGIC, 1'b0, 1'b1, 1'b0);
      fop(ccs_pkg::FOP_NONE, 1'b0, 1'b0, 1'b1);
      cx(ccs_pkg::CTX_NORMAL, 1'b1, 1'b1);
      op(ccs_pkg::IP_IRQ, 12'h0F0, 8'h00);
      cx(ccs_pkg::CTX_IRQ, 1'b0, 1'b0);
      fop(ccs_pkg::FOP_BITTEST, 1'b0, 1'b0, 1'b1);
      cx(ccs_pkg::CTX_IRQ, 1'b1, 1'b0);
      fop(ccs_pkg::FOP_ROTL, 1'b0, 1'b1, 1'b0);
      cx(ccs_pkg::CTX_IRQ, 1'b0, 1'b1);
      op(ccs_pkg::IP_INT_EXIT, 12'h000, 8'h00);
      cx(ccs_pkg::CTX_NORMAL, 1'b1, 1'b1);
      op(ccs_pkg::IP_NMI, 12'h0FC, 8'h00);
      cx(ccs_pkg::CTX_NMI, 1'b1, 1'b1);
      op(ccs_pkg::IP_INT_EXIT, 12'h000, 8'h00);
      cx(ccs_pkg::CTX_NORMAL, 1'b1, 1'b1);
      op(ccs_pkg::IP_NEXT, 12'h000, 8'h00);
      op(ccs_pkg::IP_REL, 12'h000, 8'hF0);
      op(ccs_pkg::IP_REL, 12'h000, 8'h7F);
      // Seven nested calls: the stack saturates and the oldest entry is lost
      for (int i = 0; i < 7; i++) op(ccs_pkg::IP_CALL, 12'h100 + 12'(i * 16), 8'h00);
      for (int i = 0; i < 7; i++) op(ccs_pkg::IP_SUB_EXIT, 12'h000, 8'h00);
      cx(ccs_pkg::CTX_NORMAL, 1'b1, 1'b1);
      chk(12'(sum_register), 12'h0EE, "sum kept over calls");
      op(ccs_pkg::IP_CALL, 12'h3A0, 8'h00);
      op(ccs_pkg::IP_CALL, 12'h3B0, 8'h00);
      rst();
      op(ccs_pkg::IP_SUB_EXIT, 12'h000, 8'h00);
      print_verdict();
   end

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #(25 * 4000);
      n_fail++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule : cpu_context_and_call_stack_tb
